// File: rtl/acs_sequencer.sv
// Purpose: Conversion sequencer for a four-input 8-bit converter core.
// Assumes: All inputs synchronous to ref_clk; pulses last one cycle.
// Notes:   Core handshake is exchanged on the divided converter tick.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

// How it works
// - Reset returns all control and status to defaults, flags cleared.
// - Reset loads the slowest clock division.
// - Converter clock is core clock divided by field plus one.
// - First conversion after reset waits a start-up delay.
// - Clearing module enable halts all conversion activity.
// - Stop clears start, aborts running and discards pending conversions.
// - Stop also kills timer work but keeps timer trigger enabled.
// - Clearing timer enable drops pending timer work, running one completes.
// - Four event flags, each with an enable, feed one interrupt.
// - Interrupt is a level while any enabled flag is set.
// - Single mode converts the addressed channel and marks new data.
// - Scan converts selected channels ascending; one-shot clears start at begin.
// - Each scanned channel sets done flag; cycle flag at the end.
// - Scan lasts channels times conversion time, repeats same selection.
// - Last converted channel is reported in single modes.
// - Unread result overwritten by new one sets overrun flag.
// - Timer conversion launches on trigger rising edge.
// - Timer and software requests interleave, each waits for the other.
// - Mode 00 is single channel, 01 is scan.
module acs_sequencer
(
    input  wire logic                               ref_clk,
    input  wire logic                               rst,
    input  wire acs_pkg::acs_ctrl_s                 ctrl,
    input  wire logic [`ACS_DIV_W-1:0]              clkDivField,
    input  wire logic                               startSet,
    input  wire logic                               stopReq,
    input  wire logic [3:0]                         flagClear,
    input  wire logic [`ACS_NUM_CH-1:0]             resultRead,
    input  wire logic [`ACS_CH_W-1:0]               swChannelField,
    input  wire logic [`ACS_CH_W-1:0]               timerChannelField,
    input  wire logic [`ACS_NUM_CH-1:0]             scanChannelBit,
    input  wire logic                               timerTriggerPulse,
    input  wire logic                               coreDone,
    input  wire logic [`ACS_RES_W-1:0]              coreResult,
    output logic                                    startStatus,
    output logic [3:0]                              convStatus,
    output logic                                    converterIrq,
    output acs_pkg::acs_result_s [`ACS_NUM_CH-1:0]  channelResult,
    output logic [`ACS_CH_W-1:0]                    lastChannel,
    output logic                                    coreStart,
    output logic [`ACS_CH_W-1:0]                    coreChannel,
    output logic                                    convClk
);
    import acs_pkg::*;

    localparam logic [`ACS_WARM_W-1:0] WarmLast = `ACS_WARM_W'(`ACS_START_DELAY_CYC - 1);

    acs_seq_state_s             s;
    acs_seq_state_s             next_s;
    logic                       tick;
    logic [3:0]                 irqTerm;
    logic                       trigRise;
    logic                       isScan;
    logic                       pickTimer;
    logic                       doneNow;

    // ------------------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------------------
    acs_clk_div u_div
    (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .moduleEnable (ctrl.moduleEnable),
        .clkDivField  (clkDivField),
        .tick         (tick),
        .convClk      (convClk)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Lowest selected channel of a scan mask
    function automatic logic [`ACS_CH_W-1:0] lowestCh(input logic [`ACS_NUM_CH-1:0] mask);
        logic [`ACS_CH_W-1:0] idx;
        idx = '0;
        for (int i = `ACS_NUM_CH - 1; i >= 0; i--)
        begin
            if (mask[i])
            begin
                idx = `ACS_CH_W'(i);
            end
        end
        return idx;
    endfunction

    // Decoded request terms
    assign trigRise  = timerTriggerPulse && !s.trigPrev;
    assign isScan    = (ctrl.convModeField == `ACS_MODE_SCAN);
    assign pickTimer = s.timerPend && (!s.startBit || isScan || !s.lastTimer);
    assign doneNow   = (s.phase == ACS_BUSY) && tick && coreDone;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.coreStart = 1'b0;
        next_s.trigPrev = timerTriggerPulse;

        // Software start is write-one-to-set
        if (startSet)
        begin
            next_s.startBit = 1'b1;
        end

        // Timer requests only in single mode, dropped when disabled
        if (ctrl.timerTriggerEnable && trigRise && !isScan)
        begin
            next_s.timerPend = 1'b1;
        end
        if (!ctrl.timerTriggerEnable)
        begin
            next_s.timerPend = 1'b0;
        end

        // Flags: clear first so a same-cycle event wins
        next_s.flags = s.flags & ~flagClear;
        for (int i = 0; i < `ACS_NUM_CH; i++)
        begin
            if (resultRead[i])
            begin
                next_s.results[i].newData = 1'b0;
            end
        end

        case (s.phase)
            ACS_IDLE:
            begin
                if (ctrl.moduleEnable && (s.startBit || s.timerPend))
                begin
                    if (!s.warmed)
                    begin
                        next_s.phase = ACS_WARMUP;
                        next_s.warmCnt = '0;
                    end
                    else if (isScan && s.startBit)
                    begin
                        next_s.curScan = 1'b1;
                        next_s.curTimer = 1'b0;
                        next_s.scanLeft = scanChannelBit;
                        if (!ctrl.repeatEnable)
                        begin
                            next_s.startBit = 1'b0;
                        end
                        if (scanChannelBit == '0)
                        begin
                            next_s.flags[`ACS_FLAG_CYCLE] = 1'b1;
                        end
                        else
                        begin
                            next_s.curCh = lowestCh(scanChannelBit);
                            next_s.phase = ACS_LAUNCH;
                        end
                    end
                    else if (pickTimer && !isScan)
                    begin
                        next_s.curScan = 1'b0;
                        next_s.curTimer = 1'b1;
                        next_s.timerPend = 1'b0;
                        next_s.curCh = timerChannelField;
                        next_s.phase = ACS_LAUNCH;
                    end
                    else if (s.startBit && !isScan)
                    begin
                        next_s.curScan = 1'b0;
                        next_s.curTimer = 1'b0;
                        next_s.curCh = swChannelField;
                        if (!ctrl.repeatEnable)
                        begin
                            next_s.startBit = 1'b0;
                        end
                        next_s.phase = ACS_LAUNCH;
                    end
                end
            end

            ACS_WARMUP:
            begin
                next_s.warmCnt = s.warmCnt + 1'b1;
                if (s.warmCnt >= WarmLast)
                begin
                    next_s.warmed = 1'b1;
                    next_s.phase = ACS_IDLE;
                end
            end

            ACS_LAUNCH:
            begin
                if (tick)
                begin
                    next_s.coreStart = 1'b1;
                    next_s.phase = ACS_BUSY;
                end
            end

            ACS_BUSY:
            begin
                if (tick && coreDone)
                begin
                    // Store result; unread data is overwritten with overrun
                    if (s.results[s.curCh].newData && !resultRead[s.curCh])
                    begin
                        next_s.flags[`ACS_FLAG_OVR] = 1'b1;
                    end
                    next_s.results[s.curCh].value = coreResult;
                    next_s.results[s.curCh].newData = 1'b1;
                    next_s.lastTimer = s.curTimer;
                    if (s.curTimer)
                    begin
                        next_s.flags[`ACS_FLAG_TIMER] = 1'b1;
                    end
                    else
                    begin
                        next_s.flags[`ACS_FLAG_CONV] = 1'b1;
                    end
                    if (!s.curScan)
                    begin
                        next_s.lastCh = s.curCh;
                    end
                    next_s.phase = ACS_IDLE;
                    if (s.curScan)
                    begin
                        next_s.scanLeft[s.curCh] = 1'b0;
                        if ((s.scanLeft & ~(`ACS_NUM_CH'(1) << s.curCh)) != '0)
                        begin
                            next_s.curCh = lowestCh(s.scanLeft & ~(`ACS_NUM_CH'(1) << s.curCh));
                            next_s.phase = ACS_LAUNCH;
                        end
                        else
                        begin
                            next_s.flags[`ACS_FLAG_CYCLE] = 1'b1;
                            next_s.curScan = 1'b0;
                        end
                    end
                end
            end

            default:
            begin
                next_s.phase = ACS_IDLE;
            end
        endcase

        // Stop aborts everything except a start-up delay and leaves the timer enable alone
        if (stopReq)
        begin
            next_s.startBit = 1'b0;
            next_s.timerPend = 1'b0;
            next_s.curScan = 1'b0;
            next_s.coreStart = 1'b0;
            if (s.phase != ACS_WARMUP)
            begin
                next_s.phase = ACS_IDLE;
            end
        end

        // Disabled module halts all activity
        if (!ctrl.moduleEnable)
        begin
            next_s.phase = ACS_IDLE;
            next_s.startBit = 1'b0;
            next_s.timerPend = 1'b0;
            next_s.curScan = 1'b0;
            next_s.coreStart = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Everything to defaults on reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Per-flag interrupt terms
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_irq
            assign irqTerm[g] = s.flags[g] && ctrl.irqEnable[g];
        end
    endgenerate

    assign converterIrq  = |irqTerm;
    assign startStatus   = s.startBit;
    assign convStatus    = s.flags;
    assign channelResult = s.results;
    assign lastChannel   = s.lastCh;
    assign coreStart     = s.coreStart;
    assign coreChannel   = s.curCh;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    irq_level_a : assert property (@(posedge ref_clk) disable iff (rst)
        (s.flags[`ACS_FLAG_OVR] && ctrl.irqEnable[`ACS_FLAG_OVR]) |-> converterIrq)
        else $error("interrupt low while enabled overrun flag set");

    stop_abort_a : assert property (@(posedge ref_clk) disable iff (rst)
        (stopReq && s.phase == ACS_BUSY) |=> (s.phase == ACS_IDLE && !startStatus))
        else $error("stop did not abort conversion");

    stop_timer_a : assert property (@(posedge ref_clk) disable iff (rst)
        stopReq |=> !s.timerPend)
        else $error("timer request survived stop");

    timer_clear_a : assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl.timerTriggerEnable |=> !s.timerPend)
        else $error("timer request kept after enable cleared");

    disable_halt_a : assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl.moduleEnable |=> (s.phase == ACS_IDLE && !coreStart))
        else $error("activity while module disabled");

    warm_quiet_a : assert property (@(posedge ref_clk) disable iff (rst)
        (s.phase == ACS_WARMUP) |-> (!coreStart && s.warmCnt <= WarmLast))
        else $error("conversion during start-up delay");

    launch_busy_a : assert property (@(posedge ref_clk) disable iff (rst)
        coreStart |-> (s.phase == ACS_BUSY) ##1 !coreStart)
        else $error("core start without busy phase");

    overrun_set_a : assert property (@(posedge ref_clk) disable iff (rst)
        (doneNow && s.results[s.curCh].newData && !resultRead[s.curCh])
            |=> convStatus[`ACS_FLAG_OVR])
        else $error("overrun not flagged");

    result_store_a : assert property (@(posedge ref_clk) disable iff (rst)
        doneNow |=> (channelResult[$past(s.curCh)].value == $past(coreResult)
                     && channelResult[$past(s.curCh)].newData))
        else $error("result not stored with new data");

    last_ch_a : assert property (@(posedge ref_clk) disable iff (rst)
        (doneNow && !s.curScan) |=> lastChannel == $past(s.curCh))
        else $error("last channel not updated");

endmodule
`default_nettype wire

// File: rtl/acs_defs.svh
// Purpose: Constants for the converter sequencer (sizes, fields, resets, timing).
// Assumes: Core clock of 10 MHz on ref_clk.
// Notes:   Included by the package and by the design modules.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define ACS_NUM_CH          4
`define ACS_CH_W            2
`define ACS_RES_W           8
`define ACS_DIV_W           6
`define ACS_WARM_W          16

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define ACS_DIV_RESET       6'h3F
`define ACS_MODE_SINGLE     2'h0
`define ACS_MODE_SCAN       2'h1

// ----------------------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------------------
`define ACS_FLAG_CONV       0
`define ACS_FLAG_CYCLE      1
`define ACS_FLAG_TIMER      2
`define ACS_FLAG_OVR        3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACS_CLK_PERIOD_NS   100
`define ACS_START_DELAY_NS  20000
`define ACS_START_DELAY_CYC ((`ACS_START_DELAY_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

// File: rtl/acs_pkg.sv
// Purpose: Types shared by the converter sequencer modules.
// Assumes: acs_defs.svh supplies all widths except the phase, mode, enable and flag fields.
// Notes:   State of each module is one packed struct.
`include "acs_defs.svh"

package acs_pkg;

    // ------------------------------------------------------------------------
    // Sequencer phases
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {ACS_IDLE, ACS_WARMUP, ACS_LAUNCH, ACS_BUSY} acs_phase_e;

    // Per-channel result buffer
    typedef struct packed {
        logic                   newData;
        logic [`ACS_RES_W-1:0]  value;
    } acs_result_s;

    // Static configuration bits from software
    typedef struct packed {
        logic                   moduleEnable;
        logic [1:0]             convModeField;
        logic                   repeatEnable;
        logic                   timerTriggerEnable;
        logic [3:0]             irqEnable;
    } acs_ctrl_s;

    // Divider state
    typedef struct packed {
        logic [`ACS_DIV_W-1:0]  div;
        logic [`ACS_DIV_W-1:0]  cnt;
        logic                   tick;
        logic                   convClk;
    } acs_div_state_s;

    // Sequencer state
    typedef struct packed {
        acs_phase_e                         phase;
        logic                               startBit;
        logic                               timerPend;
        logic                               lastTimer;
        logic                               curTimer;
        logic                               curScan;
        logic [`ACS_NUM_CH-1:0]             scanLeft;
        logic [`ACS_CH_W-1:0]               curCh;
        logic [`ACS_CH_W-1:0]               lastCh;
        logic                               warmed;
        logic [`ACS_WARM_W-1:0]             warmCnt;
        logic                               trigPrev;
        logic                               coreStart;
        logic [3:0]                         flags;
        acs_result_s [`ACS_NUM_CH-1:0]      results;
    } acs_seq_state_s;

endpackage

// File: rtl/acs_clk_div.sv
// Purpose: Converter clock divider, core clock divided by field plus one.
// Assumes: Divider field is only changed while the module is disabled.
// Notes:   tick marks the converter clock edge in the core clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

module acs_clk_div
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   moduleEnable,
    input  wire logic [`ACS_DIV_W-1:0]  clkDivField,
    output logic                        tick,
    output logic                        convClk
);
    import acs_pkg::*;

    acs_div_state_s s;
    acs_div_state_s next_s;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Divisor follows the field while disabled, counts while enabled
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!moduleEnable)
        begin
            next_s.div = clkDivField;
            next_s.cnt = '0;
        end
        else if (s.cnt == s.div)
        begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + 1'b1;
        end
        next_s.convClk = (s.cnt <= (s.div >> 1)) && moduleEnable;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Slowest division after reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s.div <= `ACS_DIV_RESET;
            s.cnt <= '0;
            s.tick <= 1'b0;
            s.convClk <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
    assign convClk = s.convClk;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    div_load_a : assert property (@(posedge ref_clk) disable iff (rst)
        (!moduleEnable && !rst) |=> s.div == $past(clkDivField))
        else $error("divisor did not follow field while disabled");

    tick_space_a : assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s.div != '0 && moduleEnable) |=> !tick)
        else $error("converter tick faster than divisor allows");

endmodule
`default_nettype wire

// File: tb/acs_sequencer_tb.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Divider field 0 until the final divide-by-three check, so the core handshake is live every cycle.
// Notes:   The bench stands in for software and for the converter core.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

module acs_sequencer_tb;
    import acs_pkg::*;
    logic                   ref_clk, rst, startSet, stopReq, timerTriggerPulse, coreDone;
    acs_ctrl_s              ctrl;
    logic [5:0]             clkDivField;
    logic [3:0]             flagClear, resultRead, scanChannelBit, convStatus;
    logic [1:0]             swChannelField, timerChannelField, lastChannel, coreChannel;
    logic [7:0]             coreResult;
    logic                   startStatus, converterIrq, coreStart, convClk;
    acs_result_s [3:0]      channelResult;
    int                     numErrors = 0;
    int                     cmpCount = 0;
    int                     n;

    acs_sequencer uut (.ref_clk, .rst, .ctrl, .clkDivField, .startSet, .stopReq, .flagClear,
        .resultRead, .swChannelField, .timerChannelField, .scanChannelBit, .timerTriggerPulse,
        .coreDone, .coreResult, .startStatus, .convStatus, .converterIrq, .channelResult,
        .lastChannel, .coreStart, .coreChannel, .convClk);

    // ------------------------------------------------------------------------
    // Clock, compare, verdict
    // ------------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            numErrors++;
        end
    endtask

    task automatic complete_run;
        $display("Compares %0d, errors %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Plays the core: waits for a start, checks the channel, returns a result
    task automatic conv(input logic [1:0] ch, input logic [7:0] res);
        n = 0;
        do @(negedge ref_clk); while (coreStart !== 1'b1 && ++n < 400);
        chk({coreStart, coreChannel}, {1'b1, ch});
        @(posedge ref_clk) {coreDone, coreResult} <= {1'b1, res};
        @(posedge ref_clk) coreDone <= 1'b0;
        @(negedge ref_clk) chk(channelResult[ch].value, res);
    endtask

    // Reconfigures while disabled, then enables again
    task automatic setup(input logic [1:0] mode, input logic rpt, input logic [1:0] sw);
        @(posedge ref_clk) {ctrl.moduleEnable, ctrl.timerTriggerEnable, flagClear} <= 6'h0F;
        @(posedge ref_clk) {ctrl.convModeField, ctrl.repeatEnable} <= {mode, rpt};
        {flagClear, swChannelField, timerTriggerPulse} <= {4'h0, sw, 1'b0};
        @(posedge ref_clk) {ctrl.moduleEnable, resultRead} <= 5'h10;
    endtask

    task automatic start;
        @(posedge ref_clk) startSet <= 1'b1;
        @(posedge ref_clk) startSet <= 1'b0;
    endtask

    // Cuts a hang short
    initial
    begin
        #3000000;
        numErrors++;
        complete_run();
    end

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial
    begin
        {rst, ctrl, clkDivField, startSet, stopReq, flagClear, resultRead} = '1;
        {ctrl, clkDivField, startSet, stopReq, flagClear, resultRead} = '0;
        {timerTriggerPulse, coreDone, coreResult} = '0;
        {swChannelField, timerChannelField, scanChannelBit} = {2'h2, 2'h1, 4'hA};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk({startStatus, convStatus, converterIrq, coreStart, convClk}, 16'h0);
        @(posedge ref_clk) {ctrl.moduleEnable, ctrl.irqEnable} <= 5'h1F;
        start();
        conv(2'h2, 8'hA5);
        chk(16'(n >= `ACS_START_DELAY_CYC), 16'h1);
        chk({channelResult[2], convStatus, lastChannel}, {9'h1A5, 4'h1, 2'h2});
        chk({converterIrq, startStatus, convClk}, 3'b101);
        start();
        conv(2'h2, 8'h5A);
        chk(convStatus, 4'h9);
        @(posedge ref_clk) {flagClear, resultRead} <= 8'hFF;
        @(posedge ref_clk) {flagClear, resultRead} <= 8'h00;
        @(negedge ref_clk) chk({converterIrq, convStatus, channelResult[2].newData}, 0);
        @(posedge ref_clk) {ctrl.timerTriggerEnable, timerTriggerPulse} <= 2'b11;
        conv(2'h1, 8'h3C);
        chk({convStatus, lastChannel}, {4'h4, 2'h1});
        setup(`ACS_MODE_SCAN, 1'b0, 2'h2);
        start();
        conv(2'h1, 8'h11);
        chk(convStatus[1:0], 2'b01);
        conv(2'h3, 8'h33);
        chk({convStatus[1:0], startStatus}, 3'b110);
        setup(`ACS_MODE_SINGLE, 1'b1, 2'h0);
        start();
        conv(2'h0, 8'h77);
        n = 0;
        do @(negedge ref_clk); while (coreStart !== 1'b1 && ++n < 50);
        chk({coreStart, startStatus}, 2'b11);
        @(posedge ref_clk) stopReq <= 1'b1;
        @(posedge ref_clk) {stopReq, coreDone, coreResult} <= {2'b01, 8'h99};
        @(posedge ref_clk) coreDone <= 1'b0;
        @(negedge ref_clk) chk({startStatus, channelResult[0].value}, {1'b0, 8'h77});
        // Let the stop settle, clear flags, then try a divide-by-three converter clock
        repeat (10) @(posedge ref_clk);
        @(posedge ref_clk) {ctrl.moduleEnable, flagClear} <= 5'h0F;
        @(posedge ref_clk) {flagClear, clkDivField} <= 10'h002;
        @(posedge ref_clk) ctrl.moduleEnable <= 1'b1;
        repeat (4) @(posedge ref_clk);
        n = 0;
        repeat (6) @(negedge ref_clk) n += convClk;
        chk({convStatus, 12'(n)}, 16'h0004);
        complete_run();
    end
endmodule
`default_nettype wire
